/* design/fep_top.sv */
// receive fifo and the coding, carrier and negotiation logic
`timescale 1ns/1ps
module fep_fifo #(
   parameter int W = 6,
   parameter int DEPTH = 16
)(
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   // depth must be a power of two so the pointers wrap by themselves
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } fep_fifo_st_t;
   fep_fifo_st_t q;
   fep_fifo_st_t d;
   logic push;
   logic pop;
   assign in_ready = (q.cnt != (AW+1)'(DEPTH));
   assign out_valid = q.ov;
   assign out_data = q.od;
   always_comb
   begin
      d = q;
      push = in_valid && in_ready;
      pop = (q.cnt != '0) && (!q.ov || out_ready);
      if (out_ready && q.ov)
      begin
         d.ov = 1'b0;
      end
      if (pop)
      begin
         d.od = q.mem[q.rp];
         d.ov = 1'b1;
         d.rp = q.rp + 1'b1;
      end
      if (push)
      begin
         d.mem[q.wp] = in_data;
         d.wp = q.wp + 1'b1;
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end
endmodule

module fep_top import fep_pkg::*; #(
   parameter int PDET_WAIT = PDET_WAIT_CYC
)(
   input wire logic clk,
   input wire logic resetn,
   input wire logic rx_nrzi,
   input wire logic rx_man,
   input wire logic tx_en,
   input wire logic tx_valid,
   input wire logic [3:0] txd,
   input wire logic mii_rx_ready,
   input wire logic [3:0] an_adv,
   input wire logic [3:0] lp_abil,
   input wire logic lp_valid,
   input wire logic an_restart,
   output logic tx_ready,
   output logic [4:0] tx_code,
   output logic tx_code_valid,
   output logic man_tx,
   output logic rx_valid,
   output logic [3:0] rxd,
   output logic rx_er,
   output logic rx_last,
   output logic rx_overrun,
   output logic col,
   output logic crs,
   output logic [3:0] adv_abil,
   output logic an_ack,
   output logic an_reject,
   output logic link_up,
   output logic speed100,
   output logic full_duplex,
   output logic lock100
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prevn;
      logic [10:0] lfsr;
      logic [4:0] lock_cnt;
      logic locked;
      logic [9:0] sh;
      logic in_frame;
      logic [2:0] bitcnt;
      logic pend_t;
      logic pre2;
      logic push_v;
      logic push_cg;
      logic [FIFO_W-1:0] push_w;
      logic overrun;
      logic m1;
      logic m2;
      logic m3;
      logic [4:0] since;
      logic [5:0] quiet;
      logic act10;
      logic [3:0] nib10;
      logic [1:0] bcnt10;
      logic busy;
      logic [3:0] tsh;
      logic [1:0] tbits;
      logic [3:0] half;
      logic phase;
      logic man_tx;
      logic tx_ready;
      logic [4:0] tx5;
      logic tx5_v;
      logic col;
      logic crs;
      fep_an_t an;
      logic [31:0] timer;
      logic [3:0] adv;
      logic ack;
      logic reject;
      logic link;
      logic spd100;
      logic fdx;
   } fep_st_t;

   fep_st_t st_q;
   fep_st_t st_d;
   logic fifo_ready;
   logic [FIFO_W-1:0] fifo_out;
   logic rx_act;

   function automatic logic [4:0] fep_dec(input logic [4:0] cg);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++)
      begin
         if (ENC_TAB[i] == cg)
         begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // highest common mode first: 100 full, 100 half, 10 full, 10 half
   function automatic logic [1:0] fep_prio(input logic [3:0] com);
      logic [1:0] r;
      r = {1'b0, 1'b0};
      if (com[AB_100F])
      begin
         r = 2'h3;
      end
      else if (com[AB_100H])
      begin
         r = 2'h2;
      end
      else if (com[AB_10F])
      begin
         r = 2'h1;
      end
      return r;
   endfunction

   assign rx_act = st_q.spd100 ? st_q.in_frame : st_q.act10;

   always_comb
   begin
      logic nrz;
      logic key;
      logic plain;
      logic [4:0] cg;
      logic [4:0] dv;
      logic [3:0] com;
      logic [1:0] pm;
      nrz = 1'b0;
      key = 1'b0;
      plain = 1'b0;
      cg = 5'h00;
      dv = 5'h00;
      com = 4'h0;
      pm = 2'h0;
      st_d = st_q;
      st_d.push_v = 1'b0;
      st_d.push_cg = 1'b0;
      st_d.reject = 1'b0;
      st_d.tx5_v = 1'b0;
      st_d.s1 = rx_nrzi; // RL9
      st_d.s2 = st_q.s1;
      st_d.prevn = st_q.s2;
      nrz = st_q.s2 ^ st_q.prevn; // RL7
      key = st_q.lfsr[10] ^ st_q.lfsr[8];
      // before lock the line is taken as idle, so the key is inverted nrz
      if (st_q.locked)
      begin
         plain = nrz ^ key; // RL8
         st_d.lfsr = {st_q.lfsr[9:0], key};
      end
      else
      begin
         plain = 1'b1;
         st_d.lfsr = {st_q.lfsr[9:0], ~nrz};
         st_d.lock_cnt = (key == ~nrz) ? st_q.lock_cnt + 1'b1 : 5'h00;
         st_d.locked = (st_q.lock_cnt == LOCK_ONES);
      end
      st_d.sh = {st_q.sh[8:0], plain};
      cg = st_d.sh[4:0];
      dv = fep_dec(cg);
      if (st_q.pre2)
      begin
         st_d.pre2 = 1'b0;
         st_d.push_v = st_q.spd100;
         st_d.push_w = {2'b00, NIB_PRE}; // RL3
      end
      if (!st_q.in_frame)
      begin
         if (st_d.sh == {CG_J, CG_K} && st_q.locked) // RL2 RL6
         begin
            st_d.in_frame = 1'b1;
            st_d.bitcnt = 3'h0;
            st_d.pend_t = 1'b0;
            st_d.pre2 = 1'b1;
            st_d.push_v = st_q.spd100;
            st_d.push_w = {2'b00, NIB_PRE}; // RL3
         end
      end
      else if (st_q.bitcnt == 3'h4)
      begin
         st_d.bitcnt = 3'h0; // RL6
         st_d.push_v = st_q.spd100; // RL10
         st_d.push_cg = 1'b1;
         if (st_q.pend_t)
         begin
            st_d.pend_t = 1'b0;
            st_d.in_frame = 1'b0;
            st_d.push_cg = 1'b0;
            st_d.push_w = {1'b1, (cg != CG_R), 4'h0}; // RL4
         end
         else if (cg == CG_T)
         begin
            st_d.pend_t = 1'b1; // RL4
            st_d.push_v = 1'b0;
            st_d.push_cg = 1'b0;
         end
         else if (cg == CG_I)
         begin
            st_d.in_frame = 1'b0;
            st_d.push_cg = 1'b0;
            st_d.push_w = {2'b11, 4'h0}; // RL23
         end
         else if (dv[4])
         begin
            st_d.push_w = {2'b00, dv[3:0]}; // RL5
         end
         else
         begin
            st_d.push_w = {2'b01, 4'h0}; // RL23
         end
      end
      else
      begin
         st_d.bitcnt = st_q.bitcnt + 1'b1;
      end
      // ten megabit receive: a mid-bit edge gives the bit, lsb first
      st_d.m1 = rx_man;
      st_d.m2 = st_q.m1;
      st_d.m3 = st_q.m2;
      if (st_q.since != 5'h1f)
      begin
         st_d.since = st_q.since + 1'b1;
      end
      if (st_q.quiet != QUIET10_CYC)
      begin
         st_d.quiet = st_q.quiet + 1'b1;
      end
      if (st_q.m2 != st_q.m3)
      begin
         st_d.quiet = 6'h00;
         if (st_q.since >= MID_MIN_CYC)
         begin
            st_d.since = 5'h00;
            st_d.nib10 = {st_q.m2, st_q.nib10[3:1]}; // RL13
            st_d.bcnt10 = st_q.bcnt10 + 1'b1;
            if (st_q.bcnt10 == 2'h3 && !st_q.spd100)
            begin
               st_d.push_v = 1'b1; // RL11 RL13
               st_d.push_w = {2'b00, st_q.m2, st_q.nib10[3:1]};
            end
         end
      end
      st_d.act10 = (st_d.quiet != QUIET10_CYC);
      // cleared as activity ends, so the edge that starts it still counts
      if (!st_d.act10 && st_q.act10)
      begin
         st_d.bcnt10 = 2'h0;
      end
      if (!st_d.act10 && st_q.act10 && !st_q.spd100)
      begin
         st_d.push_v = 1'b1;
         st_d.push_w = {1'b1, (st_q.bcnt10 != 2'h0), 4'h0};
      end
      if (st_q.push_v && !fifo_ready)
      begin
         st_d.overrun = 1'b1;
      end
      // transmit: 5-bit groups at 100, manchester at 10
      if (tx_valid && st_q.tx_ready && st_q.spd100)
      begin
         st_d.tx5 = ENC_TAB[txd]; // RL1
         st_d.tx5_v = 1'b1;
      end
      if (st_q.busy)
      begin
         st_d.half = st_q.half + 1'b1;
         if (st_q.half == HALF10_CYC - 1'b1)
         begin
            st_d.half = 4'h0;
            st_d.phase = ~st_q.phase;
            if (st_q.phase)
            begin
               st_d.tsh = {1'b0, st_q.tsh[3:1]}; // RL12
               st_d.tbits = st_q.tbits + 1'b1;
               st_d.busy = (st_q.tbits != 2'h3);
            end
         end
      end
      else if (tx_valid && st_q.tx_ready && !st_q.spd100)
      begin
         st_d.busy = 1'b1; // RL11 RL12
         st_d.tsh = txd;
         st_d.tbits = 2'h0;
         st_d.half = 4'h0;
         st_d.phase = 1'b0;
      end
      // a one is low then high across the bit cell
      st_d.man_tx = st_d.busy && (st_d.phase ? st_d.tsh[0] : ~st_d.tsh[0]);
      st_d.tx_ready = st_d.spd100 || !st_d.busy;
      st_d.col = !st_q.fdx && tx_en && rx_act; // RL14 RL15 RL16
      st_d.crs = rx_act || (!st_q.fdx && tx_en); // RL17 RL18
      // negotiation and parallel detection
      com = an_adv & lp_abil;
      pm = fep_prio(com);
      case (st_q.an)
         AN_ADV, AN_PDET:
         begin
            st_d.adv = an_adv; // RL19
            st_d.timer = st_q.timer + 1'b1;
            if (lp_valid)
            begin
               if (com != 4'h0)
               begin
                  st_d.ack = 1'b1; // RL19
                  st_d.link = 1'b1;
                  st_d.spd100 = pm[1]; // RL20
                  st_d.fdx = pm[0];
                  st_d.an = AN_LINK;
               end
               else
               begin
                  st_d.reject = 1'b1; // RL19
               end
            end
            else if (st_q.an == AN_PDET)
            begin
               if (st_q.locked && an_adv[AB_100H]) // RL21
               begin
                  st_d.link = 1'b1; // RL22
                  st_d.spd100 = 1'b1;
                  st_d.fdx = 1'b0;
                  st_d.an = AN_LINK;
               end
               else if (st_q.act10 && an_adv[AB_10H]) // RL21
               begin
                  st_d.link = 1'b1; // RL22
                  st_d.spd100 = 1'b0;
                  st_d.fdx = 1'b0;
                  st_d.an = AN_LINK;
               end
            end
            else if (st_q.timer == 32'(PDET_WAIT - 1))
            begin
               st_d.an = AN_PDET;
            end
         end
         AN_LINK:
         begin
            if (an_restart)
            begin
               st_d.an = AN_ADV;
               st_d.timer = 32'h0;
               st_d.ack = 1'b0;
               st_d.link = 1'b0;
            end
         end
         default:
         begin
            st_d.an = AN_ADV;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= '0;
         st_q.spd100 <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // the line cannot be stalled, so a full fifo drops and flags overrun
   fep_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(st_q.push_v),
      .in_data(st_q.push_w),
      .in_ready(fifo_ready),
      .out_valid(rx_valid),
      .out_data(fifo_out),
      .out_ready(mii_rx_ready)
   );

   assign rxd = fifo_out[3:0];
   assign rx_er = fifo_out[W_ER];
   assign rx_last = fifo_out[W_LAST];
   assign rx_overrun = st_q.overrun;
   assign tx_ready = st_q.tx_ready;
   assign tx_code = st_q.tx5;
   assign tx_code_valid = st_q.tx5_v;
   assign man_tx = st_q.man_tx;
   assign col = st_q.col;
   assign crs = st_q.crs;
   assign adv_abil = st_q.adv;
   assign an_ack = st_q.ack;
   assign an_reject = st_q.reject;
   assign link_up = st_q.link;
   assign speed100 = st_q.spd100;
   assign full_duplex = st_q.fdx;
   assign lock100 = st_q.locked;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence pre_push_s;
      st_q.push_v && st_q.push_w == {2'b00, NIB_PRE} && !st_q.push_cg;
   endsequence
   sequence pre_pair_s;
      pre_push_s ##1 pre_push_s;
   endsequence
   sequence tx10_load_s;
      tx_valid && tx_ready && !speed100 && !st_q.busy;
   endsequence

   enc_map_a: assert property ( // RL1
      tx_code_valid |-> tx_code == ENC_TAB[$past(txd)])
      else $error("code group does not match nibble");
   jk_preamble_a: assert property ( // RL2
      $rose(st_q.in_frame) && speed100 |-> pre_pair_s)
      else $error("start delimiter not replaced by two preamble nibbles");
   tr_strip_a: assert property ( // RL4
      $fell(st_q.in_frame) && speed100 |->
      st_q.push_v && st_q.push_w[W_LAST] && st_q.push_w[3:0] == 4'h0)
      else $error("frame end not marked by end marker");
   dec_lookup_a: assert property ( // RL5
      st_q.push_v && st_q.push_cg && !st_q.push_w[W_ER] |->
      ENC_TAB[st_q.push_w[3:0]] == st_q.sh[4:0])
      else $error("decoded nibble does not match code group");
   rx_chain_a: assert property ( // RL8
      st_q.locked && $past(st_q.locked) |-> st_q.sh[0] ==
      $past(st_q.s2 ^ st_q.prevn ^ st_q.lfsr[10] ^ st_q.lfsr[8]))
      else $error("descrambled bit wrong");
   bad_code_a: assert property ( // RL23
      st_q.push_v && st_q.push_cg |->
      st_q.push_w[W_ER] == !fep_dec(st_q.sh[4:0])[4])
      else $error("invalid code group error flag wrong");
   man_first_a: assert property ( // RL12
      tx10_load_s |=> man_tx == ~$past(txd[0]) ##1
      man_tx == ~$past(txd[0], 2) ##1 man_tx == ~$past(txd[0], 3) ##1
      man_tx == ~$past(txd[0], 4) ##1 man_tx == ~$past(txd[0], 5) ##1
      man_tx == ~$past(txd[0], 6) ##1 man_tx == $past(txd[0], 7))
      else $error("manchester cell wrong");
   col_half_a: assert property ( // RL14
      tx_en && rx_act && !full_duplex |=> col)
      else $error("collision not reported");
   col_full_a: assert property ( // RL16
      full_duplex && $past(full_duplex) |-> !col)
      else $error("collision in full duplex");
   crs_mode_a: assert property ( // RL18
      ##1 crs == $past(rx_act || (tx_en && !full_duplex)))
      else $error("carrier sense wrong");
   an_prio_a: assert property ( // RL20
      st_q.an != AN_LINK && lp_valid && an_adv[AB_100F] &&
      lp_abil[AB_100F] |=> link_up && speed100 && full_duplex && an_ack)
      else $error("highest common mode not chosen");
   an_reject_a: assert property ( // RL19
      st_q.an != AN_LINK && lp_valid && (an_adv & lp_abil) == 4'h0
      |=> an_reject && !link_up)
      else $error("unshared modes not rejected");
   pdet_a: assert property ( // RL22
      st_q.an == AN_PDET && !lp_valid && lock100 && an_adv[AB_100H]
      |=> link_up && speed100 && !full_duplex)
      else $error("parallel detection did not bring link up");
endmodule

/* design/fep_pkg.sv */
// constants, code table and types of the fast ethernet coding block
// Operation
// RL1: each data nibble maps to its fixed 5-bit code group from one table.
// RL2: a frame starts when the code groups J (11000) and K (10001) arrive.
// RL3: the J/K pair is dropped and two 0101 preamble nibbles go out.
// RL4: the closing T (01101) and R (00111) groups are not passed on.
// RL5: aligned code groups decode to nibbles by the inverse table lookup.
// RL6: alignment starts at J/K and stays on that 5-bit boundary.
// RL7: the recovered NRZI bit stream is turned into NRZ first.
// RL8: NRZ bits are descrambled before code-group alignment.
// RL9: logic runs on the recovered 125 MHz clock with synchronized data.
// RL10: at 100 Mb/s line data becomes synchronous 4-bit nibbles.
// RL11: at 10 Mb/s Manchester coding replaces 4B/5B coding.
// RL12: 10 Mb/s transmit serialises MAC nibbles then Manchester encodes.
// RL13: 10 Mb/s receive Manchester decodes and assembles nibbles.
// RL14: in half duplex simultaneous transmit and receive is a collision.
// RL15: a detected collision raises the collision output.
// RL16: in full duplex the collision output never rises.
// RL17: in half duplex carrier sense shows transmit or receive.
// RL18: in full duplex carrier sense shows receive only.
// RL19: advertise own modes, acknowledge partner modes, reject unshared ones.
// RL20: several common modes resolve by a fixed priority order.
// RL21: a silent partner is handled by examining the received signal.
// RL22: a detected supported technology brings the link up in it.
// RL23: idle is 11111; error or invalid groups in a frame flag an error.
package fep_pkg;
   localparam logic [4:0] CG_J = 5'h18;
   localparam logic [4:0] CG_K = 5'h11;
   localparam logic [4:0] CG_T = 5'h0d;
   localparam logic [4:0] CG_R = 5'h07;
   localparam logic [4:0] CG_I = 5'h1f;
   localparam logic [3:0] NIB_PRE = 4'h5;
   // entry n is the code group of nibble n
   localparam logic [15:0][4:0] ENC_TAB = {
      5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
      5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
   localparam int CLK_NS = 8;
   localparam int BIT10_NS = 100;
   localparam int BIT10_CYC = BIT10_NS / CLK_NS;
   localparam logic [3:0] HALF10_CYC = 4'(BIT10_CYC / 2);
   localparam logic [4:0] MID_MIN_CYC = 5'((BIT10_CYC * 3) / 4);
   localparam logic [5:0] QUIET10_CYC = 6'(2 * BIT10_CYC);
   localparam logic [4:0] LOCK_ONES = 5'h1e;
   localparam int PDET_WAIT_US = 1000;
   localparam int PDET_WAIT_CYC = (PDET_WAIT_US * 1000) / CLK_NS;
   localparam int AB_10H = 0;
   localparam int AB_10F = 1;
   localparam int AB_100H = 2;
   localparam int AB_100F = 3;
   localparam int FIFO_W = 6;
   localparam int FIFO_DEPTH = 16;
   localparam int W_LAST = 5;
   localparam int W_ER = 4;
   typedef enum logic [1:0] {AN_ADV, AN_PDET, AN_LINK} fep_an_t;
endpackage

/* dv/fep_partner.sv */
// far-end model: scrambled nrzi 100M line and 10M manchester line
`timescale 1ns/1ps
module fep_partner (
   input wire logic clk,
   output logic rx_nrzi,
   output logic rx_man
);
   logic [10:0] key_q = 11'h7ff;
   logic ks;
   logic b;
   logic q[$];
   initial rx_nrzi = 1'b0;
   initial rx_man = 1'b0;
   // one bit per clock; idle ones fill gaps so the far end keeps its lock
   always @(negedge clk)
   begin
      b = (q.size() > 0) ? q.pop_front() : 1'b1;
      ks = key_q[10] ^ key_q[8];
      key_q = {key_q[9:0], ks};
      rx_nrzi <= rx_nrzi ^ (b ^ ks);
   end
   // code groups leave msb first
   task automatic send_cg(input logic [4:0] cg);
      for (int i = 4; i >= 0; i--)
         q.push_back(cg[i]);
   endtask
   // bit cell: complement for 6 cycles, then the bit; lsb first
   task automatic send_man(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         rx_man <= ~v[i];
         repeat (6) @(negedge clk);
         rx_man <= v[i];
         repeat (5) @(negedge clk);
      end
   endtask
endmodule

/* dv/test_fast_ethernet_pcs_coding.sv */
// self-checking bench for the fast ethernet coding block
`timescale 1ns/1ps
`define fep_chk(nm, e, g) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("BAD %s exp %0h got %0h", nm, e, g); \
      end \
   end
module test_fast_ethernet_pcs_coding import fep_pkg::*;;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic rx_nrzi, rx_man, tx_en, tx_valid, mii_rx_ready, lp_valid;
   logic an_restart;
   logic [3:0] txd, an_adv, lp_abil;
   logic tx_ready, tx_code_valid, man_tx, rx_valid, rx_er, rx_last;
   logic rx_overrun, col, crs, an_ack, an_reject, link_up, speed100;
   logic full_duplex, lock100;
   logic [4:0] tx_code;
   logic [3:0] rxd, adv_abil;
   int errors = 0;
   int cmp_count = 0;
   logic [5:0] rxq[$];
   // own copy of the code table so a wrong design table shows up
   logic [4:0] tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
      5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

   always #4 clk = ~clk;

   // short wait keeps parallel detection inside a few hundred cycles
   fep_top #(.PDET_WAIT(50)) dut_u (.clk(clk), .resetn(resetn),
      .rx_nrzi(rx_nrzi), .rx_man(rx_man), .tx_en(tx_en),
      .tx_valid(tx_valid), .txd(txd), .mii_rx_ready(mii_rx_ready),
      .an_adv(an_adv), .lp_abil(lp_abil), .lp_valid(lp_valid),
      .an_restart(an_restart), .tx_ready(tx_ready), .tx_code(tx_code),
      .tx_code_valid(tx_code_valid), .man_tx(man_tx),
      .rx_valid(rx_valid), .rxd(rxd), .rx_er(rx_er), .rx_last(rx_last),
      .rx_overrun(rx_overrun), .col(col), .crs(crs),
      .adv_abil(adv_abil), .an_ack(an_ack), .an_reject(an_reject),
      .link_up(link_up), .speed100(speed100),
      .full_duplex(full_duplex), .lock100(lock100));

   fep_partner p_u (.clk(clk), .rx_nrzi(rx_nrzi), .rx_man(rx_man));

   always @(posedge clk)
      if (rx_valid === 1'b1 && mii_rx_ready === 1'b1)
         rxq.push_back({rx_last, rx_er, rxd});

   task automatic send_cgs(input logic [4:0] c[$]);
      foreach (c[i])
         p_u.send_cg(c[i]);
   endtask

   // extra cycles after the last word let a stray word show up
   task automatic expect_words(input logic [5:0] e[$]);
      int n;
      n = 0;
      while (rxq.size() < e.size() && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      repeat (8) @(posedge clk);
      `fep_chk("word count", e.size(), rxq.size())
      foreach (e[i])
         if (i < rxq.size())
            `fep_chk("rx word", e[i], rxq[i])
      rxq.delete();
   endtask

   task automatic t_tx100;
      for (int i = 0; i < 16; i++)
      begin
         @(negedge clk);
         tx_valid = 1'b1;
         txd = 4'(i);
         @(posedge clk);
         #1;
         `fep_chk("tx_code_valid", 1'b1, tx_code_valid)
         `fep_chk("tx_code", tab[i], tx_code)
      end
      @(negedge clk);
      tx_valid = 1'b0;
      @(posedge clk);
      #1;
      `fep_chk("tx_code_valid low", 1'b0, tx_code_valid)
      $display("done tx100");
   endtask

   task automatic t_rx100;
      logic [4:0] c[$];
      logic [5:0] e[$];
      int n;
      n = 0;
      while (lock100 !== 1'b1 && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      `fep_chk("lock100", 1'b1, lock100)
      c = '{5'h18, 5'h11};
      e = '{6'h05, 6'h05};
      for (int i = 0; i < 16; i++)
      begin
         c.push_back(tab[i]);
         e.push_back(6'(i));
      end
      c.push_back(5'h0d);
      c.push_back(5'h07);
      e.push_back(6'h20);
      send_cgs(c);
      expect_words(e);
      // error group mid-frame, then idle instead of the end pair
      send_cgs('{5'h18, 5'h11, tab[3], 5'h04, tab[4]});
      expect_words('{6'h05, 6'h05, 6'h03, 6'h10, 6'h04, 6'h30});
      $display("done rx100");
   endtask

   task automatic t_fifo;
      logic [4:0] c[$];
      logic [5:0] e[$];
      c = '{5'h18, 5'h11};
      e = '{6'h05, 6'h05};
      for (int i = 0; i < 20; i++)
         c.push_back(tab[0]);
      // sixteen words in the fifo plus one in its output register
      for (int i = 0; i < 15; i++)
         e.push_back(6'h00);
      c.push_back(5'h0d);
      c.push_back(5'h07);
      @(negedge clk);
      mii_rx_ready = 1'b0;
      send_cgs(c);
      repeat (150) @(posedge clk);
      #1;
      `fep_chk("rx_overrun", 1'b1, rx_overrun)
      @(negedge clk);
      mii_rx_ready = 1'b1;
      expect_words(e);
      `fep_chk("fifo empty", 1'b0, rx_valid)
      $display("done fifo");
   endtask

   task automatic t_col(input logic fdx);
      logic [4:0] c[$];
      c = '{5'h18, 5'h11};
      for (int i = 0; i < 12; i++)
         c.push_back(tab[0]);
      c.push_back(5'h0d);
      c.push_back(5'h07);
      send_cgs(c);
      repeat (40) @(negedge clk);
      tx_en = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `fep_chk("crs rx", 1'b1, crs)
      `fep_chk("col", ~fdx, col)
      repeat (80) @(posedge clk);
      #1;
      `fep_chk("crs tx only", ~fdx, crs)
      `fep_chk("col tx only", 1'b0, col)
      @(negedge clk);
      tx_en = 1'b0;
      rxq.delete();
      $display("done col");
   endtask

   task automatic restart;
      @(negedge clk);
      an_restart = 1'b1;
      @(negedge clk);
      an_restart = 1'b0;
      `fep_chk("link down", 1'b0, link_up)
   endtask

   // lr = {link_up, an_reject}; sf = {speed100, full_duplex} when linked
   task automatic an_page(input logic [3:0] lp, input logic [1:0] lr,
      input logic [1:0] sf);
      @(negedge clk);
      lp_abil = lp;
      lp_valid = 1'b1;
      @(posedge clk);
      #1;
      `fep_chk("link/reject", lr, {link_up, an_reject})
      `fep_chk("an_ack", lr[1], an_ack)
      `fep_chk("adv_abil", an_adv, adv_abil)
      if (lr[1])
         `fep_chk("mode", sf, {speed100, full_duplex})
      @(negedge clk);
      lp_valid = 1'b0;
      $display("done an page");
   endtask

   task automatic t_tx10;
      logic [3:0] v;
      v = 4'h6;
      @(negedge clk);
      tx_valid = 1'b1;
      txd = v;
      @(posedge clk);
      for (int k = 0; k < 48; k++)
      begin
         #1;
         `fep_chk("man_tx", v[k / 12] ^ (k % 12 < 6), man_tx)
         `fep_chk("tx_ready busy", 1'b0, tx_ready)
         @(negedge clk);
         tx_valid = 1'b0;
         @(posedge clk);
      end
      #1;
      `fep_chk("tx_ready back", 1'b1, tx_ready)
      $display("done tx10");
   endtask

   task automatic t_pdet;
      int n;
      restart();
      n = 0;
      while (link_up !== 1'b1 && n < 200)
      begin
         @(posedge clk);
         n++;
      end
      #1;
      `fep_chk("pdet mode", 3'b110, {link_up, speed100, full_duplex})
      // no 100 ability: only 10M line activity may bring the link up
      @(negedge clk);
      an_adv = 4'h1;
      restart();
      p_u.send_man(8'ha5);
      #1;
      `fep_chk("pdet10 mode", 3'b100, {link_up, speed100, full_duplex})
      `fep_chk("adv_abil pdet", 4'h1, adv_abil)
      repeat (40) @(posedge clk);
      rxq.delete();
      $display("done pdet");
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // tests take about a thousand cycles; this leaves a wide margin
   initial
   begin
      #(8 * 20000);
      errors++;
      print_verdict();
   end

   initial
   begin
      tx_en = 1'b0;
      tx_valid = 1'b0;
      txd = 4'h0;
      mii_rx_ready = 1'b1;
      an_adv = 4'hf;
      lp_abil = 4'h0;
      lp_valid = 1'b0;
      an_restart = 1'b0;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      t_tx100();
      t_rx100();
      t_fifo();
      t_col(1'b0);
      restart();
      an_page(4'hc, 2'b10, 2'b11);
      t_col(1'b1);
      restart();
      an_page(4'h0, 2'b01, 2'b00);
      an_page(4'h3, 2'b10, 2'b01);
      t_tx10();
      p_u.send_man(8'h39);
      expect_words('{6'h09, 6'h03, 6'h20});
      $display("done rx10");
      t_pdet();
      print_verdict();
   end
endmodule
